// File: shared/pbi_consts.svh
// Register layout and timing constants for the phase interrupt flags
`ifndef PBI_CONSTS_SVH
`define PBI_CONSTS_SVH

`define PBI_SEL_FLAGS      1'h0
`define PBI_SEL_TOP        1'h1
`define PBI_BIT_ILIM       0
`define PBI_BIT_SHORT      1
`define PBI_BIT_PG         2
`define PBI_PHASE_STRIDE   4
`define PBI_FLAG_MASK      8'h77
`define PBI_RSVD_MASK      8'h88
`define PBI_FLAGS_RESET    8'h00
`define PBI_TOP_RESET      8'h00
`define PBI_TOP_RSVD_MASK  8'hfe
`define PBI_TOP_PEND_BIT   0
`define PBI_STARTUP_MS     1
`define PBI_CLK_KHZ        40000
`define PBI_STARTUP_CYCLES (`PBI_STARTUP_MS * `PBI_CLK_KHZ)

`endif

// File: shared/pbi_pkg.sv
// Types shared by the phase interrupt flag logic
package pbi_pkg;
  typedef enum logic [2:0] {
    PBI_OFF      = 3'h1,
    PBI_STARTING = 3'h2,
    PBI_RUNNING  = 3'h4
  } pbi_phase_state_e;
endpackage

// File: shared/pbi_phase_if.sv
// Per-phase link between the flag register and its start-up watcher
`timescale 1ns/1ps
`default_nettype none
interface pbi_phase_if;
  logic enable;
  logic above_floor;
  logic short_evt;
  modport mon (input enable, input above_floor, output short_evt);
  modport top (output enable, output above_floor, input short_evt);
endinterface
`default_nettype wire

// File: design/pbi_startup_watch.sv
// Start-up timeout and output-drop detector for one phase
`timescale 1ns/1ps
`default_nettype none
`include "pbi_consts.svh"
module pbi_startup_watch #(
  parameter int unsigned STARTUP_CYCLES = `PBI_STARTUP_CYCLES,
  parameter int unsigned CNT_W          = 16
) (
  input  wire logic clk,
  input  wire logic arst_n,
  pbi_phase_if.mon  ph
);
  pbi_pkg::pbi_phase_state_e state;
  pbi_pkg::pbi_phase_state_e next_state;
  logic [CNT_W-1:0]          cnt;
  logic [CNT_W-1:0]          next_cnt;
  logic                      above_prev;
  logic                      short_evt;
  logic                      next_short_evt;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(STARTUP_CYCLES - 1);

  if (STARTUP_CYCLES < 2 || STARTUP_CYCLES > (2 ** CNT_W)) begin : g_chk
    $error("pbi_startup_watch: STARTUP_CYCLES does not fit CNT_W");
  end

  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_short_evt = 1'b0;
    case (state)
      pbi_pkg::PBI_OFF: begin
        next_cnt = '0;
        if (ph.enable) begin
          next_state = pbi_pkg::PBI_STARTING;
        end
      end
      pbi_pkg::PBI_STARTING: begin
        if (!ph.enable) begin
          next_state = pbi_pkg::PBI_OFF;
        end else if (ph.above_floor) begin
          next_state = pbi_pkg::PBI_RUNNING;
        end else if (cnt == LAST) begin
          next_short_evt = 1'b1;
          next_state     = pbi_pkg::PBI_RUNNING;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      pbi_pkg::PBI_RUNNING: begin
        if (!ph.enable) begin
          next_state = pbi_pkg::PBI_OFF;
        end else if (above_prev && !ph.above_floor) begin
          // Edge, not level: a dead output flags once, not every cycle
          next_short_evt = 1'b1;
        end
      end
      default: begin
        next_state = pbi_pkg::PBI_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= pbi_pkg::PBI_OFF;
      cnt        <= '0;
      above_prev <= 1'b0;
      short_evt  <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      above_prev <= ph.above_floor;
      short_evt  <= next_short_evt;
    end
  end

  assign ph.short_evt = short_evt;

  a_timeout_short: assert property (@(posedge clk) disable iff (!arst_n)
    state == pbi_pkg::PBI_STARTING && ph.enable && !ph.above_floor
      && cnt == LAST |=> short_evt)
    else $error("start-up timeout did not raise short event");

  a_drop_short: assert property (@(posedge clk) disable iff (!arst_n)
    state == pbi_pkg::PBI_RUNNING && ph.enable && above_prev
      && !ph.above_floor |=> short_evt)
    else $error("output drop did not raise short event");
endmodule
`default_nettype wire

// File: design/pbi_flags.sv
// Latched phase 0/1 interrupt flags with write-one-to-clear access
`timescale 1ns/1ps
`default_nettype none
`include "pbi_consts.svh"
// How it works
// - Each phase latches a power-good flag when its output reaches threshold.
// - Each phase latches a short flag when its running output drops below 0.35 V.
// - Short flag also sets if output misses 0.35 V within 1 ms of enable.
// - Each phase latches a current-limit flag when its current limit activates.
// - Flags hold until software writes one; writing zero leaves them alone.
// - Phase 0 flags sit at bits 0..2, phase 1 at 4..6; 3, 7 reserved.
// - Summary pending bit in top register follows any flag still set.
module pbi_flags #(
  parameter int unsigned STARTUP_CYCLES = `PBI_STARTUP_CYCLES,
  parameter int unsigned CNT_W          = 16
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [1:0] phase_enable,
  input  wire logic [1:0] phase_pg_ok,
  input  wire logic [1:0] phase_above_floor,
  input  wire logic [1:0] phase_ilim_active,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_wr_sel,
  input  wire logic [7:0] reg_wr_data,
  output logic      [7:0] flag_reg,
  output logic      [7:0] top_reg
);
  localparam int NPH = 2;

  // Two-stage synchronisers for the analog and pin inputs
  logic [NPH-1:0] en_meta;
  logic [NPH-1:0] pg_meta;
  logic [NPH-1:0] fl_meta;
  logic [NPH-1:0] il_meta;
  logic [NPH-1:0] en_sync;
  logic [NPH-1:0] pg_sync;
  logic [NPH-1:0] fl_sync;
  logic [NPH-1:0] il_sync;
  logic [NPH-1:0] pg_prev;
  logic [NPH-1:0] il_prev;
  logic [NPH-1:0] pg_rise;
  logic [NPH-1:0] il_rise;
  logic [NPH-1:0] short_evt;
  logic [7:0]     set_vec;
  logic [7:0]     next_flags;
  logic [7:0]     next_top;
  logic           wr_flags;
  logic           wr_top;

  function automatic int unsigned flag_pos(input int unsigned phase,
                                           input int unsigned bitpos);
    flag_pos = phase * `PBI_PHASE_STRIDE + bitpos;
  endfunction

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_meta <= '0;
      pg_meta <= '0;
      fl_meta <= '0;
      il_meta <= '0;
      en_sync <= '0;
      pg_sync <= '0;
      fl_sync <= '0;
      il_sync <= '0;
      pg_prev <= '0;
      il_prev <= '0;
    end else begin
      en_meta <= phase_enable;
      pg_meta <= phase_pg_ok;
      fl_meta <= phase_above_floor;
      il_meta <= phase_ilim_active;
      en_sync <= en_meta;
      pg_sync <= pg_meta;
      fl_sync <= fl_meta;
      il_sync <= il_meta;
      pg_prev <= pg_sync;
      il_prev <= il_sync;
    end
  end

  // Edges, so a flag that software clears is not relatched by a held level
  assign pg_rise = pg_sync & ~pg_prev;
  assign il_rise = il_sync & ~il_prev;

  for (genvar p = 0; p < NPH; p++) begin : g_phase
    pbi_phase_if ph ();
    assign ph.enable      = en_sync[p];
    assign ph.above_floor = fl_sync[p];
    assign short_evt[p]   = ph.short_evt;

    pbi_startup_watch #(
      .STARTUP_CYCLES (STARTUP_CYCLES),
      .CNT_W          (CNT_W)
    ) u_watch (
      .clk    (clk),
      .arst_n (arst_n),
      .ph     (ph)
    );
  end

  always_comb begin
    set_vec = '0;
    for (int unsigned p = 0; p < NPH; p++) begin
      set_vec[flag_pos(p, `PBI_BIT_ILIM)]  = il_rise[p];
      set_vec[flag_pos(p, `PBI_BIT_SHORT)] = short_evt[p];
      set_vec[flag_pos(p, `PBI_BIT_PG)]    = pg_rise[p];
    end
  end

  assign wr_flags = reg_wr_en && reg_wr_sel == `PBI_SEL_FLAGS;
  assign wr_top   = reg_wr_en && reg_wr_sel == `PBI_SEL_TOP;

  always_comb begin
    next_flags = flag_reg;
    if (wr_flags) begin
      // Ones clear flags, zeros keep; reserved bits are plain storage
      next_flags = (flag_reg & ~reg_wr_data & `PBI_FLAG_MASK)
                 | (reg_wr_data & `PBI_RSVD_MASK);
    end
    // Set wins over a clear in the same cycle
    next_flags = next_flags | (set_vec & `PBI_FLAG_MASK);
  end

  always_comb begin
    next_top = top_reg & `PBI_TOP_RSVD_MASK;
    if (wr_top) begin
      next_top = reg_wr_data & `PBI_TOP_RSVD_MASK;
    end
    // From next_flags so the summary never lags the flags
    next_top[`PBI_TOP_PEND_BIT] = |(next_flags & `PBI_FLAG_MASK);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg <= `PBI_FLAGS_RESET;
      top_reg  <= `PBI_TOP_RESET;
    end else begin
      flag_reg <= next_flags;
      top_reg  <= next_top;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  for (genvar p = 0; p < NPH; p++) begin : g_chk
    localparam int unsigned PG = p * `PBI_PHASE_STRIDE + `PBI_BIT_PG;
    localparam int unsigned SC = p * `PBI_PHASE_STRIDE + `PBI_BIT_SHORT;
    localparam int unsigned IL = p * `PBI_PHASE_STRIDE + `PBI_BIT_ILIM;

    a_pg_latch: assert property (
      $rose(pg_sync[p]) |=> flag_reg[PG])
      else $error("power-good flag not set on threshold crossing");

    a_short_latch: assert property (
      short_evt[p] |=> flag_reg[SC])
      else $error("short flag not set on short event");

    a_ilim_latch: assert property (
      $rose(il_sync[p]) |=> flag_reg[IL])
      else $error("current-limit flag not set on limit onset");

    a_pin_to_flag: assert property (
      $rose(phase_pg_ok[p]) ##1 phase_pg_ok[p] [*3] ##0
        !(reg_wr_en && reg_wr_sel == `PBI_SEL_FLAGS)
        |=> flag_reg[PG])
      else $error("power-good pin did not reach its flag bit");

    a_stale_set: assert property (
      $rose(flag_reg[IL]) |-> $past(il_rise[p]))
      else $error("current-limit flag set without its own event");
  end

  // Per bit, so every ordinary clear write exercises both checks
  a_zero_keeps: assert property (
    wr_flags |=> ($past(flag_reg) & ~$past(reg_wr_data) & `PBI_FLAG_MASK
      & ~flag_reg) == 8'h00)
    else $error("writing zero cleared a flag");

  a_one_clears: assert property (
    wr_flags && set_vec == 8'h00 |=>
      (flag_reg & $past(reg_wr_data) & `PBI_FLAG_MASK) == 8'h00)
    else $error("writing ones did not clear the flags");

  a_summary_bit: assert property (
    top_reg[`PBI_TOP_PEND_BIT] == |(flag_reg & `PBI_FLAG_MASK))
    else $error("summary bit disagrees with the flags");

  a_rsvd_store: assert property (
    wr_flags |=> (flag_reg & `PBI_RSVD_MASK)
      == ($past(reg_wr_data) & `PBI_RSVD_MASK))
    else $error("reserved bits did not store the written value");

  a_rsvd_hold: assert property (
    !wr_flags |=> (flag_reg & `PBI_RSVD_MASK)
      == ($past(flag_reg) & `PBI_RSVD_MASK))
    else $error("reserved bits changed without a write");
endmodule
`default_nettype wire

// File: bench/pbi_host_model.sv
// Host side model that issues register writes to the flag block
`timescale 1ns/1ps
`default_nettype none
module pbi_host_model (
  input  wire logic       clk,
  output var  logic       wr_en,
  output var  logic       wr_sel,
  output var  logic [7:0] wr_data
);
  initial begin
    wr_en   = 1'b0;
    wr_sel  = 1'b0;
    wr_data = 8'h00;
  end
  // Data parked at its inverse so a stale byte never looks valid
  task automatic write(input logic sel, input logic [7:0] data);
    @(posedge clk);
    wr_en   <= 1'b1;
    wr_sel  <= sel;
    wr_data <= data;
    @(posedge clk);
    wr_en   <= 1'b0;
    wr_data <= ~data;
    @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// File: bench/test_buck_phase_interrupt_flags.sv
// Self-checking bench for the phase 0/1 interrupt flags
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
  comparisons++; \
  if ((got) !== (ex)) begin \
    n_fail++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end
module test_buck_phase_interrupt_flags;
  // Short start-up window keeps the run brief
  localparam int unsigned SU = 20;
  logic       clk;
  logic       arst_n;
  logic [1:0] en;
  logic [1:0] pg;
  logic [1:0] floor_ok;
  logic [1:0] ilim;
  logic       wr_en;
  logic       wr_sel;
  logic [7:0] wr_data;
  logic [7:0] flag_reg;
  logic [7:0] top_reg;
  int         n_fail;
  int         comparisons;

  pbi_flags #(.STARTUP_CYCLES(SU), .CNT_W(16)) i_dut (
    .clk(clk), .arst_n(arst_n), .phase_enable(en), .phase_pg_ok(pg),
    .phase_above_floor(floor_ok), .phase_ilim_active(ilim),
    .reg_wr_en(wr_en), .reg_wr_sel(wr_sel), .reg_wr_data(wr_data),
    .flag_reg(flag_reg), .top_reg(top_reg));
  pbi_host_model i_host (
    .clk(clk), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data));

  task automatic test_done();
    $display("Checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wait_set(input logic [7:0] m);
    for (int i = 0; i < SU + 12; i++) begin
      @(posedge clk);
      #1;
      if ((flag_reg & m) === m)
        return;
    end
    n_fail++;
    $display("Error wait_set expected %h seen %h", m, flag_reg);
    test_done();
  endtask

  task automatic t_event(input int p, input bit is_pg);
    logic [7:0] m;
    m = 8'h01 << (p * 4 + (is_pg ? 2 : 0));
    @(posedge clk);
    if (is_pg)
      pg[p] <= 1'b1;
    else
      ilim[p] <= 1'b1;
    wait_set(m);
    `CHK("flag set", m, flag_reg)
    `CHK("summary", 8'h01, top_reg)
    i_host.write(1'b0, ~m & 8'h77);
    `CHK("write zero", m, flag_reg)
    i_host.write(1'b0, m);
    `CHK("cleared", 8'h00, flag_reg)
    `CHK("summary off", 8'h00, top_reg)
    repeat (5) @(posedge clk);
    #1;
    `CHK("held level", 8'h00, flag_reg)
    @(posedge clk);
    pg[p]   <= 1'b0;
    ilim[p] <= 1'b0;
  endtask

  task automatic t_timeout();
    @(posedge clk);
    en[1] <= 1'b1;
    // Two sync edges, one to enter start-up, one to latch the event
    repeat (SU + 3) @(posedge clk);
    #1;
    `CHK("no early short", 8'h00, flag_reg)
    @(posedge clk);
    #1;
    `CHK("startup short", 8'h20, flag_reg)
    i_host.write(1'b0, 8'h20);
    @(posedge clk);
    en[1] <= 1'b0;
  endtask

  // Clear lands in the cycle the events latch; set must win
  task automatic t_race();
    @(posedge clk);
    ilim[0] <= 1'b1;
    pg[1]   <= 1'b1;
    @(posedge clk);
    i_host.write(1'b0, 8'h01);
    `CHK("set beats clear", 8'h41, flag_reg)
    i_host.write(1'b0, 8'h01);
    `CHK("one cleared", 8'h40, flag_reg)
    `CHK("summary holds", 8'h01, top_reg)
    i_host.write(1'b0, 8'h40);
    `CHK("race cleared", 8'h00, flag_reg)
    `CHK("summary clears", 8'h00, top_reg)
    @(posedge clk);
    ilim[0] <= 1'b0;
    pg[1]   <= 1'b0;
  endtask

  task automatic t_drop();
    @(posedge clk);
    floor_ok[0] <= 1'b1;
    en[0]       <= 1'b1;
    repeat (SU + 8) @(posedge clk);
    #1;
    `CHK("running no short", 8'h00, flag_reg)
    @(posedge clk);
    floor_ok[0] <= 1'b0;
    wait_set(8'h02);
    `CHK("drop short", 8'h02, flag_reg)
    i_host.write(1'b0, 8'h02);
    @(posedge clk);
    en[0] <= 1'b0;
  endtask

  task automatic t_reserved();
    i_host.write(1'b0, 8'h88);
    `CHK("reserved store", 8'h88, flag_reg)
    `CHK("reserved no summary", 8'h00, top_reg)
    i_host.write(1'b1, 8'hff);
    `CHK("top store", 8'hfe, top_reg)
    // Reset in mid-run must drop stored reserved bits too
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("rereset flags", 8'h00, flag_reg)
    `CHK("rereset top", 8'h00, top_reg)
    @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("released flags", 8'h00, flag_reg)
    i_host.write(1'b1, 8'h02);
    `CHK("top after reset", 8'h02, top_reg)
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    arst_n      = 1'b0;
    en          = 2'b00;
    pg          = 2'b00;
    floor_ok    = 2'b00;
    ilim        = 2'b00;
    n_fail      = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("reset flags", 8'h00, flag_reg)
    `CHK("reset top", 8'h00, top_reg)
    for (int p = 0; p < 2; p++) begin
      t_event(p, 1'b1);
      t_event(p, 1'b0);
    end
    t_race();
    t_timeout();
    t_drop();
    t_reserved();
    test_done();
  end
endmodule
`default_nettype wire
